// ### pkg/ssu_pkg.sv
package ssu_pkg;
  // register offsets on the plain register port
  localparam logic [3:0] SSU_REG_TXDATA = 4'h0;
  localparam logic [3:0] SSU_REG_RXDATA = 4'h1;
  localparam logic [3:0] SSU_REG_STATUS = 4'h2;
  localparam logic [3:0] SSU_REG_CTRL   = 4'h3;
  localparam logic [3:0] SSU_REG_BAUD   = 4'h4;
  localparam logic [3:0] SSU_REG_PORT   = 4'h5;
  // status bit positions
  localparam int SSU_ST_TXE  = 7;
  localparam int SSU_ST_RXF  = 6;
  localparam int SSU_ST_OVR  = 5;
  localparam int SSU_ST_FRM  = 4;
  localparam int SSU_ST_PAR  = 3;
  localparam int SSU_ST_TEND = 2;
  // control bit positions
  localparam int SSU_CT_TE   = 0;
  localparam int SSU_CT_RE   = 1;
  localparam int SSU_CT_RIE  = 2;
  localparam int SSU_CT_SYNC = 3;
  localparam int SSU_CT_PEN  = 4;
  localparam int SSU_CT_PODD = 5;
  localparam int SSU_CT_CKHI = 6;
  localparam int SSU_CT_CKLO = 7;
  // port bit positions
  localparam int SSU_PT_TXD  = 0;
  localparam int SSU_PT_TXDD = 1;
  localparam int SSU_PT_SCKD = 2;
  localparam int SSU_PT_SCKDD = 3;
  localparam logic [7:0] SSU_STATUS_RST = 8'h84;
  localparam logic [7:0] SSU_CTRL_RST   = 8'h00;
  localparam logic [7:0] SSU_BAUD_RST   = 8'h0f;
  localparam logic [7:0] SSU_PORT_RST   = 8'h00;
  // timing
  localparam int SSU_OVERSAMPLE = 16;
  localparam int SSU_SAMPLE_PT  = 8;
  localparam int SSU_CLK_MHZ    = 250;
  localparam int SSU_DTC_GAP_CYC = 5;

  typedef enum logic [1:0] {
    SSU_RX_IDLE  = 2'b00,
    SSU_RX_START = 2'b01,
    SSU_RX_DATA  = 2'b10,
    SSU_RX_STOP  = 2'b11
  } ssu_rx_e;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
    logic       transfer_controller;
  } ssu_bus_s;

  typedef struct packed {
    logic o;
    logic oe_n;
  } ssu_pin_s;
endpackage

// ### logic/ssu_serial.sv
// Our own choices: the plain strobed port and the address map.
`timescale 1ns/1ns
`default_nettype none
module ssu_serial
  import ssu_pkg::*;
(
  input  wire logic            clk_sys,
  input  wire logic            resetn,
  input  wire ssu_pkg::ssu_bus_s bus,
  output logic [7:0]           rdata,
  input  wire logic            rxd_pin,
  input  wire logic            sck_in,
  output ssu_pkg::ssu_pin_s    txd,
  output ssu_pkg::ssu_pin_s    sck,
  output logic                 rx_full_irq,
  output logic                 rx_error_irq
);
  import ssu_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [1:0] rxd_sync, sck_sync;
  logic       sck_prev;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rxd_sync <= 2'b11;
      sck_sync <= 2'b11;
      sck_prev <= 1'b1;
    end else begin
      rxd_sync <= {rxd_sync[0], rxd_pin};
      sck_sync <= {sck_sync[0], sck_in};
      sck_prev <= sck_sync[1];
    end
  end
  wire logic rxd_s   = rxd_sync[1];
  wire logic ext_rise = sck_sync[1] & ~sck_prev;
  wire logic ext_fall = ~sck_sync[1] & sck_prev;

  ////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0] tx_data_reg, rx_data_reg, ctrl, baud, port, status;
  logic [7:0] next_tx_data_reg, next_rx_data_reg, next_ctrl, next_baud, next_port;
  logic [7:0] next_rdata;
  wire logic tx_enable_bit = ctrl[SSU_CT_TE];
  wire logic rx_enable_bit = ctrl[SSU_CT_RE];
  wire logic rx_irq_enable = ctrl[SSU_CT_RIE];
  wire logic sync_mode     = ctrl[SSU_CT_SYNC];
  wire logic clock_source_select_hi = ctrl[SSU_CT_CKHI];
  wire logic clock_out_select_lo    = ctrl[SSU_CT_CKLO];
  wire logic port_data_bit = port[SSU_PT_TXD];
  wire logic wr_txd  = bus.wr && bus.addr == SSU_REG_TXDATA;
  wire logic wr_stat = bus.wr && bus.addr == SSU_REG_STATUS;
  wire logic dtc_rd  = bus.rd && bus.transfer_controller && bus.addr == SSU_REG_RXDATA;

  always_comb begin
    next_ctrl = ctrl;
    next_baud = baud;
    next_port = port;
    next_tx_data_reg = tx_data_reg;
    if (bus.wr) begin
      case (bus.addr)
        SSU_REG_TXDATA: next_tx_data_reg = bus.wdata;
        SSU_REG_CTRL:   next_ctrl = bus.wdata;
        SSU_REG_BAUD:   next_baud = bus.wdata;
        SSU_REG_PORT:   next_port = bus.wdata;
        default: ;
      endcase
    end
    next_rdata = 8'h00;
    if (bus.rd) begin
      case (bus.addr)
        SSU_REG_TXDATA: next_rdata = tx_data_reg;
        SSU_REG_RXDATA: next_rdata = rx_data_reg;
        SSU_REG_STATUS: next_rdata = status;
        SSU_REG_CTRL:   next_rdata = ctrl;
        SSU_REG_BAUD:   next_rdata = baud;
        SSU_REG_PORT:   next_rdata = port;
        default:        next_rdata = 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // 16x basic clock and sync bit clock
  logic [7:0] bdiv, next_bdiv;
  logic [3:0] sdiv, next_sdiv;
  logic       int_sck, next_int_sck;
  wire logic  tick = (bdiv == 8'h00);
  always_comb begin
    next_bdiv = tick ? baud : bdiv - 8'h01;
    next_sdiv = sdiv;
    next_int_sck = int_sck;
    if (tick) begin
      next_sdiv = sdiv + 4'h1;
      if (sdiv == 4'(SSU_OVERSAMPLE/2 - 1) || sdiv == 4'(SSU_OVERSAMPLE - 1))
        next_int_sck = ~int_sck;
    end
  end
  wire logic int_fall = tick && (sdiv == 4'(SSU_OVERSAMPLE/2 - 1)) && int_sck;
  wire logic int_rise = tick && (sdiv == 4'(SSU_OVERSAMPLE - 1)) && !int_sck;
  wire logic sck_ext  = clock_source_select_hi;
  wire logic s_fall   = sck_ext ? ext_fall : int_fall;
  wire logic s_rise   = sck_ext ? ext_rise : int_rise;
  wire logic a_bit    = tick && sdiv == 4'(SSU_OVERSAMPLE - 1);

  ////////////////////////////////////////////////////////////////////////
  // transmitter
  logic [9:0] tx_shift_reg, next_tx_shift_reg;
  logic [3:0] tx_cnt, next_tx_cnt;
  logic       tx_busy, next_tx_busy;
  logic       tx_line, next_tx_line;
  logic       txe, next_txe, tend, next_tend;
  logic       ovr, frm, par, rxf;
  wire logic  any_err = ovr | frm | par;
  wire logic  tx_step = sync_mode ? s_fall : a_bit;
  always_comb begin
    next_tx_shift_reg = tx_shift_reg;
    next_tx_cnt = tx_cnt;
    next_tx_busy = tx_busy;
    next_tx_line = tx_line;
    next_txe = txe;
    next_tend = tend;
    if (wr_stat && !bus.wdata[SSU_ST_TXE]) next_txe = 1'b0;
    if (wr_txd && bus.transfer_controller) next_txe = 1'b0;
    if (!tx_enable_bit) begin
      next_tx_busy = 1'b0;
      next_tx_cnt = 4'h0;
      next_tx_line = 1'b1;
      next_txe = 1'b1;
      next_tend = 1'b1;
    end else if (tx_step) begin
      if (tx_busy) begin
        next_tx_line = tx_shift_reg[0];
        next_tx_shift_reg = {1'b1, tx_shift_reg[9:1]};
        next_tx_cnt = tx_cnt - 4'h1;
        if (tx_cnt == 4'h1) next_tx_busy = 1'b0;
      end else if (!txe && !(sync_mode && any_err)) begin
        next_tx_shift_reg = sync_mode ? {2'b11, tx_data_reg} : {1'b1, tx_data_reg, 1'b0};
        next_tx_cnt = sync_mode ? 4'd8 : 4'd10;
        next_tx_busy = 1'b1;
        next_txe = 1'b1;
        next_tend = 1'b0;
      end else begin
        next_tend = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // receiver
  ssu_rx_e    rx_st, next_rx_st;
  logic [3:0] rx_ph, next_rx_ph, rx_cnt, next_rx_cnt;
  logic [8:0] rx_shift_reg, next_rx_shift_reg;
  logic       next_ovr, next_frm, next_par, next_rxf;
  logic       frame_done;
  logic       stop_bad, par_bad;
  always_comb begin
    next_rx_st = rx_st;
    next_rx_ph = rx_ph;
    next_rx_cnt = rx_cnt;
    next_rx_shift_reg = rx_shift_reg;
    frame_done = 1'b0;
    stop_bad = 1'b0;
    par_bad = 1'b0;
    if (!rx_enable_bit) begin
      next_rx_st = SSU_RX_IDLE;
    end else if (sync_mode) begin
      if (!any_err && s_rise) begin
        next_rx_shift_reg = {1'b0, rxd_s, rx_shift_reg[7:1]};
        next_rx_cnt = rx_cnt + 4'h1;
        if (rx_cnt == 4'd7) begin
          next_rx_cnt = 4'h0;
          frame_done = 1'b1;
        end
      end
    end else if (tick) begin
      next_rx_ph = rx_ph + 4'h1;
      case (rx_st)
        SSU_RX_IDLE: if (!rxd_s) begin
          next_rx_st = SSU_RX_START;
          next_rx_ph = 4'h1;
        end
        SSU_RX_START: if (rx_ph == 4'(SSU_SAMPLE_PT - 1)) begin
          next_rx_st = rxd_s ? SSU_RX_IDLE : SSU_RX_DATA;
          next_rx_cnt = 4'h0;
        end
        SSU_RX_DATA: if (rx_ph == 4'(SSU_SAMPLE_PT - 1)) begin
          next_rx_shift_reg = {rxd_s, rx_shift_reg[8:1]};
          next_rx_cnt = rx_cnt + 4'h1;
          if (rx_cnt == (ctrl[SSU_CT_PEN] ? 4'd8 : 4'd7)) next_rx_st = SSU_RX_STOP;
        end
        SSU_RX_STOP: if (rx_ph == 4'(SSU_SAMPLE_PT - 1)) begin
          frame_done = 1'b1;
          stop_bad = !rxd_s;
          par_bad = ctrl[SSU_CT_PEN] && ((^rx_shift_reg) ^ ctrl[SSU_CT_PODD]);
          next_rx_st = SSU_RX_IDLE;
        end
        default: next_rx_st = SSU_RX_IDLE;
      endcase
    end
  end
  wire logic [7:0] rx_byte = (!sync_mode && ctrl[SSU_CT_PEN]) ? rx_shift_reg[7:0]
                                                               : rx_shift_reg[8:1];

  // flags: hardware set beats software clear; rx enable never clears errors
  always_comb begin
    next_ovr = ovr;
    next_frm = frm;
    next_par = par;
    next_rxf = rxf;
    next_rx_data_reg = rx_data_reg;
    if (wr_stat) begin
      if (!bus.wdata[SSU_ST_OVR]) next_ovr = 1'b0;
      if (!bus.wdata[SSU_ST_FRM]) next_frm = 1'b0;
      if (!bus.wdata[SSU_ST_PAR]) next_par = 1'b0;
      if (!bus.wdata[SSU_ST_RXF]) next_rxf = 1'b0;
    end
    if (dtc_rd) next_rxf = 1'b0;
    if (frame_done) begin
      if (stop_bad) next_frm = 1'b1;
      if (par_bad) next_par = 1'b1;
      if (rxf) begin
        next_ovr = 1'b1;
        next_rxf = 1'b1;
      end else begin
        next_rx_data_reg = sync_mode ? rx_shift_reg[8:1] : rx_byte;
        if (!stop_bad && !par_bad) next_rxf = 1'b1;
      end
    end
  end
  always_comb begin
    status = SSU_STATUS_RST & 8'h00;
    status[SSU_ST_TXE] = txe;
    status[SSU_ST_RXF] = rxf;
    status[SSU_ST_OVR] = ovr;
    status[SSU_ST_FRM] = frm;
    status[SSU_ST_PAR] = par;
    status[SSU_ST_TEND] = tend;
  end

  ////////////////////////////////////////////////////////////////////////
  // pins and interrupts
  ssu_pin_s next_txd, next_sck;
  logic     next_full_irq, next_err_irq;
  always_comb begin
    next_txd.o    = tx_enable_bit ? tx_line : port_data_bit;
    next_txd.oe_n = tx_enable_bit ? 1'b0 : ~port[SSU_PT_TXDD];
    // internal clock output idles low when the transmitter lets go, hence the dip for as long as the transmitter stays off
    if (sync_mode && !clock_source_select_hi) begin
      next_sck.o    = tx_enable_bit ? int_sck : 1'b0;
      next_sck.oe_n = 1'b0;
    end else if (!sync_mode && clock_out_select_lo) begin
      next_sck.o    = int_sck;
      next_sck.oe_n = 1'b0;
    end else if (clock_source_select_hi) begin
      next_sck.o    = 1'b1;
      next_sck.oe_n = 1'b1;
    end else begin
      next_sck.o    = port[SSU_PT_SCKD];
      next_sck.oe_n = ~port[SSU_PT_SCKDD];
    end
    next_full_irq = rxf & rx_irq_enable;
    next_err_irq  = any_err & rx_irq_enable;
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ctrl <= SSU_CTRL_RST;
      baud <= SSU_BAUD_RST;
      port <= SSU_PORT_RST;
      tx_data_reg <= 8'hff;
      rx_data_reg <= 8'h00;
      rdata <= 8'h00;
      bdiv <= 8'h00;
      sdiv <= 4'h0;
      int_sck <= 1'b1;
      tx_shift_reg <= 10'h3ff;
      tx_cnt <= 4'h0;
      tx_busy <= 1'b0;
      tx_line <= 1'b1;
      txe <= 1'b1;
      tend <= 1'b1;
      rx_st <= SSU_RX_IDLE;
      rx_ph <= 4'h0;
      rx_cnt <= 4'h0;
      rx_shift_reg <= 9'h000;
      ovr <= 1'b0;
      frm <= 1'b0;
      par <= 1'b0;
      rxf <= 1'b0;
      txd <= '{o: 1'b0, oe_n: 1'b1};
      sck <= '{o: 1'b0, oe_n: 1'b1};
      rx_full_irq <= 1'b0;
      rx_error_irq <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      baud <= next_baud;
      port <= next_port;
      tx_data_reg <= next_tx_data_reg;
      rx_data_reg <= next_rx_data_reg;
      rdata <= next_rdata;
      bdiv <= next_bdiv;
      sdiv <= next_sdiv;
      int_sck <= next_int_sck;
      tx_shift_reg <= next_tx_shift_reg;
      tx_cnt <= next_tx_cnt;
      tx_busy <= next_tx_busy;
      tx_line <= next_tx_line;
      txe <= next_txe;
      tend <= next_tend;
      rx_st <= next_rx_st;
      rx_ph <= next_rx_ph;
      rx_cnt <= next_rx_cnt;
      rx_shift_reg <= next_rx_shift_reg;
      ovr <= next_ovr;
      frm <= next_frm;
      par <= next_par;
      rxf <= next_rxf;
      txd <= next_txd;
      sck <= next_sck;
      rx_full_irq <= next_full_irq;
      rx_error_irq <= next_err_irq;
    end
  end
endmodule
`default_nettype wire

// ### tb/ssu_serial_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module ssu_serial_monitor
  import ssu_pkg::*;
(
  input wire logic              clk_sys,
  input wire logic              resetn,
  input wire ssu_pkg::ssu_bus_s bus,
  input wire logic [7:0]        rdata,
  input wire ssu_pkg::ssu_pin_s txd,
  input wire logic              rx_full_irq,
  input wire logic              rx_error_irq
);
  logic [7:0] ctl;
  logic [7:0] prt;
  logic [7:0] next_ctl;
  logic [7:0] next_prt;
  // shadow copies rebuilt from bus writes; the checker sees no internals
  always_comb begin
    next_ctl = ctl;
    next_prt = prt;
    if (bus.wr && bus.addr == SSU_REG_CTRL) next_ctl = bus.wdata;
    if (bus.wr && bus.addr == SSU_REG_PORT) next_prt = bus.wdata;
  end
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ctl <= 8'h00;
      prt <= 8'h00;
    end else begin
      ctl <= next_ctl;
      prt <= next_prt;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////////////////////////////////////////////
  // two stable cycles: one for the port register, one for the pin flop
  sequence s_port_held;
    (!ctl[SSU_CT_TE] && prt[SSU_PT_TXDD] && $stable(prt) && $stable(ctl)) [*2];
  endsequence
  sequence s_rx_off_wr;
    rx_error_irq && bus.wr && bus.addr == SSU_REG_CTRL && !bus.wdata[SSU_CT_RE] && bus.wdata[SSU_CT_RIE];
  endsequence
  sequence s_dtc_rd;
    bus.rd && bus.transfer_controller && bus.addr == SSU_REG_RXDATA;
  endsequence
  a_rd_quiet: assert property (!bus.rd |=> rdata == 8'h00)
    else $error("read data not zero outside read answer");
  a_rd_unmapped: assert property (bus.rd && bus.addr > SSU_REG_PORT |=> rdata == 8'h00)
    else $error("unmapped read returned data");
  a_pin_port: assert property (s_port_held |-> txd.o == prt[SSU_PT_TXD] && !txd.oe_n)
    else $error("transmit pin not following port bit");
  a_te_release: assert property ($fell(ctl[SSU_CT_TE]) && prt[SSU_PT_TXDD] && !prt[SSU_PT_TXD]
    |-> ##[1:2] !txd.o && !txd.oe_n)
    else $error("transmit pin not low after enable cleared");
  a_full_irq_en: assert property (rx_full_irq |-> $past(ctl[SSU_CT_RIE]))
    else $error("full request without enable");
  a_err_irq_en: assert property (rx_error_irq |-> $past(ctl[SSU_CT_RIE]))
    else $error("error request without enable");
  a_dtc_clear: assert property (s_dtc_rd |-> ##2 !rx_full_irq)
    else $error("controller read left receive full set");
  a_err_keep: assert property (s_rx_off_wr |=> rx_error_irq [*2])
    else $error("error flags lost when receiver disabled");
endmodule
bind ssu_serial ssu_serial_monitor ssu_serial_monitor_inst (.clk_sys(clk_sys), .resetn(resetn), .bus(bus),
  .rdata(rdata), .txd(txd), .rx_full_irq(rx_full_irq), .rx_error_irq(rx_error_irq));
`default_nettype wire

// ### tb/ssu_remote.sv
`timescale 1ns/1ns
`default_nettype none
module ssu_remote #(
  parameter int BIT_NS = 1024
) (
  output logic      rxd_pin,
  output logic      sck_in,
  input wire logic  txd_w
);
  // line rests at mark; no external serial clock is offered
  initial begin
    rxd_pin = 1'b1;
    sck_in = 1'b1;
  end
  task automatic send(input logic [7:0] d, input logic pen, input logic p, input logic stop);
    rxd_pin = 1'b0;
    #BIT_NS;
    for (int i = 0; i < 8; i++) begin
      rxd_pin = d[i];
      #BIT_NS;
    end
    if (pen) begin
      rxd_pin = p;
      #BIT_NS;
    end
    rxd_pin = stop;
    #BIT_NS;
    rxd_pin = 1'b1;
    #BIT_NS;
  endtask
  task automatic hold_low(input int bits);
    rxd_pin = 1'b0;
    #(bits * BIT_NS);
    rxd_pin = 1'b1;
    #(2 * BIT_NS);
  endtask
  // mid-bit sampling from the start edge
  task automatic get(output logic [7:0] d);
    @(negedge txd_w);
    #(BIT_NS + BIT_NS / 2);
    for (int i = 0; i < 8; i++) begin
      d[i] = txd_w;
      #BIT_NS;
    end
  endtask
endmodule
`default_nettype wire

// ### tb/ssu_serial_bench.sv
`timescale 1ns/1ns
`default_nettype none
module ssu_serial_bench;
  import ssu_pkg::*;
  logic       clk_sys;
  logic       resetn;
  ssu_bus_s   bus;
  ssu_pin_s   txd;
  ssu_pin_s   sck;
  logic [7:0] rdata;
  logic [7:0] rv;
  logic [7:0] tv;
  logic       rx_full_irq;
  logic       rx_error_irq;
  logic       rxd_pin;
  logic       sck_in;
  logic       txd_w;
  int         error_cnt = 0;
  int         num_checks = 0;
  int         cyc = 0;
  ssu_serial ssu_serial_inst (.clk_sys(clk_sys), .resetn(resetn), .bus(bus), .rdata(rdata), .rxd_pin(rxd_pin),
    .sck_in(sck_in), .txd(txd), .sck(sck), .rx_full_irq(rx_full_irq), .rx_error_irq(rx_error_irq));
  // pull-up holds the pin high while released
  assign txd_w = txd.oe_n ? 1'b1 : txd.o;
  ssu_remote ssu_remote_inst (.rxd_pin(rxd_pin), .sck_in(sck_in), .txd_w(txd_w));
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  // about a dozen frames of 2560 cycles; ceiling has twofold slack
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      error_cnt++;
      summarize();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0, transfer_controller: 1'b0};
    @(posedge clk_sys);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic transfer_controller, output logic [7:0] d);
    @(posedge clk_sys);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1, transfer_controller: transfer_controller};
    @(posedge clk_sys);
    bus.rd <= 1'b0;
    bus.transfer_controller <= 1'b0;
    #1;
    d = rdata;
  endtask
  task automatic poll(input int b, input logic v, input int n);
    logic [7:0] s;
    for (int i = 0; i < n; i++) begin
      rd(SSU_REG_STATUS, 1'b0, s);
      if (s[b] === v) return;
    end
    chk("status poll", {7'h00, v}, {7'h00, s[b]});
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    logic [3:0] adr [5] = '{SSU_REG_STATUS, SSU_REG_CTRL, SSU_REG_BAUD, SSU_REG_PORT, 4'hf};
    logic [7:0] exp [5] = '{SSU_STATUS_RST, SSU_CTRL_RST, SSU_BAUD_RST, SSU_PORT_RST, 8'h00};
    for (int i = 0; i < 5; i++) begin
      rd(adr[i], 1'b0, rv);
      chk("reset value", exp[i], rv);
    end
    $display("test reset done");
  endtask
  task automatic t_port_pin();
    for (int v = 0; v < 2; v++) begin
      wr(SSU_REG_PORT, {4'h0, 1'b1, v[0], 1'b1, v[0]});
      repeat (3) @(posedge clk_sys);
      #1;
      chk("txd as port", {7'h00, v[0]}, {6'h00, txd.oe_n, txd.o});
      chk("sck as port", {7'h00, v[0]}, {6'h00, sck.oe_n, sck.o});
    end
    $display("test port pin done");
  endtask
  task automatic t_tx_overwrite();
    wr(SSU_REG_CTRL, 8'h07);
    poll(SSU_ST_TXE, 1'b1, 10);
    fork
      ssu_remote_inst.get(tv);
      begin
        wr(SSU_REG_TXDATA, 8'h5a);
        wr(SSU_REG_STATUS, 8'h7f);
        wr(SSU_REG_TXDATA, 8'hc3);
        poll(SSU_ST_TXE, 1'b1, 200);
      end
    join
    chk("sent byte", 8'hc3, tv);
    $display("test transmit overwrite done");
  endtask
  task automatic t_break_send();
    wr(SSU_REG_TXDATA, 8'hff);
    wr(SSU_REG_STATUS, 8'h7f);
    repeat (600) @(posedge clk_sys);
    wr(SSU_REG_PORT, 8'h02);
    wr(SSU_REG_CTRL, 8'h06);
    repeat (3) @(posedge clk_sys);
    #1;
    chk("break level", 8'h00, {6'h00, txd.oe_n, txd.o});
    wr(SSU_REG_PORT, 8'h03);
    wr(SSU_REG_CTRL, 8'h07);
    $display("test break send done");
  endtask
  task automatic t_rx_ok();
    ssu_remote_inst.send(8'ha5, 1'b0, 1'b0, 1'b1);
    poll(SSU_ST_RXF, 1'b1, 100);
    chk("full request", 8'h01, {7'h00, rx_full_irq});
    rd(SSU_REG_RXDATA, 1'b1, rv);
    chk("received byte", 8'ha5, rv);
    rd(SSU_REG_STATUS, 1'b0, rv);
    chk("flags after controller read", 8'h00, rv & 8'h78);
    $display("test receive done");
  endtask
  task automatic t_overrun();
    ssu_remote_inst.send(8'h11, 1'b0, 1'b0, 1'b1);
    ssu_remote_inst.send(8'h22, 1'b0, 1'b0, 1'b1);
    rd(SSU_REG_STATUS, 1'b0, rv);
    chk("overrun flags", 8'h60, rv & 8'h78);
    rd(SSU_REG_RXDATA, 1'b0, rv);
    chk("kept byte", 8'h11, rv);
    chk("error request", 8'h01, {7'h00, rx_error_irq});
    wr(SSU_REG_CTRL, 8'h05);
    rd(SSU_REG_STATUS, 1'b0, rv);
    chk("flags after receiver off", 8'h60, rv & 8'h78);
    wr(SSU_REG_CTRL, 8'h07);
    wr(SSU_REG_STATUS, 8'h87);
    $display("test overrun done");
  endtask
  task automatic t_frame_err();
    wr(SSU_REG_CTRL, 8'h17);
    ssu_remote_inst.send(8'h3c, 1'b1, ~^8'h3c, 1'b0);
    rd(SSU_REG_STATUS, 1'b0, rv);
    chk("framing parity flags", 8'h18, rv & 8'h78);
    rd(SSU_REG_RXDATA, 1'b0, rv);
    chk("errored byte", 8'h3c, rv);
    wr(SSU_REG_STATUS, 8'he7);
    wr(SSU_REG_CTRL, 8'h07);
    $display("test framing done");
  endtask
  task automatic t_break_rx();
    fork
      ssu_remote_inst.hold_low(40);
      begin
        poll(SSU_ST_FRM, 1'b1, 1500);
        wr(SSU_REG_STATUS, 8'hef);
        poll(SSU_ST_FRM, 1'b1, 1500);
      end
    join
    $display("test break receive done");
  endtask
  task automatic t_sync_lock();
    wr(SSU_REG_CTRL, 8'h09);
    wr(SSU_REG_TXDATA, 8'h96);
    wr(SSU_REG_STATUS, 8'h7f);
    repeat (1000) @(posedge clk_sys);
    rd(SSU_REG_STATUS, 1'b0, rv);
    chk("transmit held", 8'h00, rv & 8'h80);
    wr(SSU_REG_STATUS, 8'he7);
    poll(SSU_ST_TXE, 1'b1, 500);
    wr(SSU_REG_CTRL, 8'h08);
    repeat (2) @(posedge clk_sys);
    #1;
    chk("clock dip", 8'h00, {6'h00, sck.oe_n, sck.o});
    wr(SSU_REG_CTRL, 8'h48);
    repeat (2) @(posedge clk_sys);
    #1;
    chk("clock released", 8'h03, {6'h00, sck.oe_n, sck.o});
    wr(SSU_REG_CTRL, 8'h40);
    wr(SSU_REG_CTRL, 8'h00);
    $display("test sync lockout done");
  endtask
  initial begin
    resetn = 1'b0;
    bus = '0;
    repeat (20) @(posedge clk_sys);
    resetn <= 1'b1;
    t_reset();
    t_port_pin();
    t_tx_overwrite();
    t_break_send();
    t_rx_ok();
    t_overrun();
    t_frame_err();
    t_break_rx();
    t_sync_lock();
    summarize();
  end
endmodule
`default_nettype wire
